// File: hw/pcc_clk_div.sv
// core and peripheral clock divider on pclk
// assumes post_factor is one of 1, 2, 4, 8 and changes only between half periods
module pcc_clk_div (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire pcc_pkg::pcc_fac_t post_factor,
    output logic                 core_clk_r,
    output logic                 periph_clk_r,
    output logic                 core_rise_r
);
    logic [3:0] half_cnt_r;
    logic       half_end;

    assign half_end = (half_cnt_r + 4'h1) >= post_factor;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt_r <= 4'h0;
            core_clk_r <= 1'b0;
        end else if (half_end) begin
            half_cnt_r <= 4'h0;
            core_clk_r <= ~core_clk_r;
        end else begin
            half_cnt_r <= half_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_clk_r <= 1'b0;
            core_rise_r  <= 1'b0;
        end else begin
            core_rise_r <= half_end && !core_clk_r;
            if (half_end && !core_clk_r) begin
                periph_clk_r <= ~periph_clk_r;
            end
        end
    end

    periph_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(periph_clk_r) |-> $rose(core_clk_r))
        else $error("peripheral clock moved without a core clock rise");
endmodule : pcc_clk_div

// File: hw/pcc_consts.svh
// register map, field layout, reset values and timing counts
// assumes 32-bit apb data, one aligned word per register
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH
`define PCC_OFS_CTRL      12'h000
`define PCC_OFS_STAT      12'h004
`define PCC_OFS_RATIO     12'h008
`define PCC_CTRL_MULT_LSB 0
`define PCC_CTRL_DIV_LSB  6
`define PCC_CTRL_HALVE    8
`define PCC_CTRL_MULT_RST 6'h06
`define PCC_STRAP_M00     6'h06
`define PCC_STRAP_M01     6'h20
`define PCC_STRAP_M10     6'h10
`define PCC_STRAP_M11     6'h06
`define PCC_REL_REF_CYC   4096
`define PCC_REL_CORE_CYC  2
`endif

// File: hw/pcc_pkg.sv
// types and decode functions of the clock and reset control
// assumes pcc_consts.svh on the include path
`include "pcc_consts.svh"
package pcc_pkg;
    typedef enum logic [1:0] {
        PCC_RS_HOLD  = 2'h0,
        PCC_RS_COUNT = 2'h1,
        PCC_RS_CORE  = 2'h3,
        PCC_RS_RUN   = 2'h2
    } pcc_rst_e;
    typedef logic [5:0] pcc_mult_t;
    typedef logic [3:0] pcc_fac_t;

    function automatic pcc_fac_t pcc_post_dec(input logic [1:0] code);
        case (code)
            2'h0:    pcc_post_dec = 4'h1;
            2'h1:    pcc_post_dec = 4'h2;
            2'h2:    pcc_post_dec = 4'h4;
            default: pcc_post_dec = 4'h8;
        endcase
    endfunction : pcc_post_dec

    function automatic pcc_mult_t pcc_strap_mult(input logic [1:0] code);
        case (code)
            2'h0:    pcc_strap_mult = `PCC_STRAP_M00;
            2'h1:    pcc_strap_mult = `PCC_STRAP_M01;
            2'h2:    pcc_strap_mult = `PCC_STRAP_M10;
            default: pcc_strap_mult = `PCC_STRAP_M11;
        endcase
    endfunction : pcc_strap_mult
endpackage : pcc_pkg

// File: hw/pcc_rst_seq.sv
// core reset release sequencer
// assumes ext_rel and ref_rise already synchronised to pclk
`include "pcc_consts.svh"
module pcc_rst_seq #(
    parameter int REF_CYC  = `PCC_REL_REF_CYC,
    parameter int CORE_CYC = `PCC_REL_CORE_CYC
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ext_rel,
    input  wire logic             ref_rise,
    input  wire logic             core_rise,
    output logic                  core_rst_n_r,
    output pcc_pkg::pcc_rst_e     state_r
);
    localparam logic [12:0] REF_LAST  = 13'(REF_CYC - 1);
    localparam logic [12:0] CORE_LAST = 13'(CORE_CYC - 1);
    logic [12:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= pcc_pkg::PCC_RS_HOLD;
            cnt_r   <= 13'h0000;
        end else if (!ext_rel) begin
            state_r <= pcc_pkg::PCC_RS_HOLD;
            cnt_r   <= 13'h0000;
        end else begin
            case (state_r)
                pcc_pkg::PCC_RS_HOLD: begin
                    state_r <= pcc_pkg::PCC_RS_COUNT;
                    cnt_r   <= 13'h0000;
                end
                pcc_pkg::PCC_RS_COUNT: begin
                    if (ref_rise && cnt_r == REF_LAST) begin
                        state_r <= pcc_pkg::PCC_RS_CORE;
                        cnt_r   <= 13'h0000;
                    end else if (ref_rise) begin
                        cnt_r <= cnt_r + 13'h0001;
                    end
                end
                pcc_pkg::PCC_RS_CORE: begin
                    if (core_rise && cnt_r == CORE_LAST) begin
                        state_r <= pcc_pkg::PCC_RS_RUN;
                    end else if (core_rise) begin
                        cnt_r <= cnt_r + 13'h0001;
                    end
                end
                default: state_r <= pcc_pkg::PCC_RS_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_rst_n_r <= 1'b0;
        end else begin
            core_rst_n_r <= ext_rel && state_r == pcc_pkg::PCC_RS_RUN;
        end
    end

    restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_rel |=> state_r == pcc_pkg::PCC_RS_HOLD && cnt_r == 13'h0000 ##1 !core_rst_n_r)
        else $error("reset reassertion did not restart the release count");
    ref_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        ext_rel && state_r == pcc_pkg::PCC_RS_COUNT && ref_rise && cnt_r == REF_LAST
        |=> state_r == pcc_pkg::PCC_RS_CORE)
        else $error("reference count end did not move to core cycle wait");
    early_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(core_rst_n_r) |-> $past(state_r) == pcc_pkg::PCC_RS_RUN
        && $past(state_r, 2) != pcc_pkg::PCC_RS_COUNT)
        else $error("core reset released before the full count");
endmodule : pcc_rst_seq

// File: hw/pcc_top.sv
// clock ratio control, core reset release and strobe pin enables
// assumes apb master on pclk; reset, strap and reference pins are asynchronous
`include "pcc_consts.svh"

////////////////////////////////////////////////////////////////////////
// Behaviour
// - vco is 2m times input; core divides by 2n
// - post divide factor 1,2,4,8 from code
// - post divide factor forced to 1 in reset
// - multiplier taken from strap pins during reset
// - input halver gives half the reference clock
// - peripheral clock period twice core clock period
// - core reset released 4096 ref plus 2 core
// - late deassertion may add one reference cycle
// - ratios set by straps or control register writes
// - strobes undriven only while reset input active
// - strap codes 00 6, 01 32, 10 16
// - core reset state driven onto output pin
module pcc_top #(
    parameter int REF_CYC  = `PCC_REL_REF_CYC,
    parameter int CORE_CYC = `PCC_REL_CORE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_reset_n,
    input  wire logic        reference_clock_in,
    input  wire logic [1:0]  startup_ratio,
    input  wire logic        core_rd_n,
    input  wire logic        core_wr_n,
    input  wire logic        core_ale,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic             ale_o,
    output logic             strobe_oe,
    output logic             core_reset_output_n,
    output logic             core_clock,
    output logic             periph_clock,
    output logic [5:0]       vco_multiplier,
    output logic [3:0]       post_divide_factor,
    output logic             input_halve_enable
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] ext_sync_r;
    logic [1:0] ref_sync_r;
    logic       ref_last_r;
    logic [1:0] strap_s1_r;
    logic [1:0] strap_s2_r;
    logic       ext_rel;
    logic       ref_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync_r <= 2'h0;
            ref_sync_r <= 2'h0;
            ref_last_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[0], ext_reset_n};
            ref_sync_r <= {ref_sync_r[0], reference_clock_in};
            ref_last_r <= ref_sync_r[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1_r <= 2'h0;
            strap_s2_r <= 2'h0;
        end else begin
            strap_s1_r <= startup_ratio;
            strap_s2_r <= strap_s1_r;
        end
    end

    assign ext_rel  = ext_sync_r[1];
    // a release just after a sample point costs one more reference edge
    assign ref_rise = ref_sync_r[1] && !ref_last_r;

    ////////////////////////////////////////////////////////////////////
    // reset release and clock division
    logic                 core_rst_n;
    pcc_pkg::pcc_rst_e    rst_state;
    logic                 core_rise;
    logic                 in_reset;

    pcc_rst_seq #(
        .REF_CYC  (REF_CYC),
        .CORE_CYC (CORE_CYC)
    ) u_rst_seq (
        .pclk         (pclk),
        .presetn      (presetn),
        .ext_rel      (ext_rel),
        .ref_rise     (ref_rise),
        .core_rise    (core_rise),
        .core_rst_n_r (core_rst_n),
        .state_r      (rst_state)
    );

    assign in_reset = !core_rst_n;

    pcc_clk_div u_clk_div (
        .pclk         (pclk),
        .presetn      (presetn),
        .post_factor  (post_divide_factor),
        .core_clk_r   (core_clock),
        .periph_clk_r (periph_clock),
        .core_rise_r  (core_rise)
    );

    ////////////////////////////////////////////////////////////////////
    // apb slave
    logic        acc;
    logic        wr_ok;
    logic        mapped;
    logic [5:0]  ctrl_mult_r;
    logic [1:0]  ctrl_div_r;
    logic        ctrl_halve_r;
    logic [6:0]  vco_num_r;
    logic [1:0]  in_div_r;
    logic [4:0]  core_den_r;

    assign acc    = psel && penable && !pready;
    assign mapped = paddr == `PCC_OFS_CTRL || paddr == `PCC_OFS_STAT
                    || paddr == `PCC_OFS_RATIO;
    assign wr_ok  = acc && pwrite && paddr == `PCC_OFS_CTRL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (acc && !pwrite) begin
            case (paddr)
                `PCC_OFS_CTRL:  prdata <= {23'h00_0000, ctrl_halve_r, ctrl_div_r, ctrl_mult_r};
                `PCC_OFS_STAT:  prdata <= {24'h00_0000, post_divide_factor, strap_s2_r,
                                           ext_rel, core_rst_n};
                `PCC_OFS_RATIO: prdata <= {11'h000, core_den_r, 6'h00, in_div_r, 1'b0, vco_num_r};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_mult_r <= `PCC_CTRL_MULT_RST;
        end else if (in_reset) begin
            ctrl_mult_r <= pcc_pkg::pcc_strap_mult(strap_s2_r);
        end else if (wr_ok && pstrb[0]) begin
            ctrl_mult_r <= pwdata[`PCC_CTRL_MULT_LSB +: 6];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_div_r <= 2'h0;
        end else if (wr_ok && pstrb[0]) begin
            ctrl_div_r <= pwdata[`PCC_CTRL_DIV_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_halve_r <= 1'b0;
        end else if (wr_ok && pstrb[1]) begin
            ctrl_halve_r <= pwdata[`PCC_CTRL_HALVE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // effective ratios
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_multiplier     <= `PCC_CTRL_MULT_RST;
            post_divide_factor <= 4'h1;
            input_halve_enable <= 1'b0;
        end else begin
            vco_multiplier     <= in_reset ? pcc_pkg::pcc_strap_mult(strap_s2_r)
                                           : ctrl_mult_r;
            post_divide_factor <= in_reset ? 4'h1
                                           : pcc_pkg::pcc_post_dec(ctrl_div_r);
            input_halve_enable <= ctrl_halve_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_num_r  <= 7'h00;
            in_div_r   <= 2'h1;
            core_den_r <= 5'h02;
        end else begin
            vco_num_r  <= {1'b0, vco_multiplier} << 1;
            in_div_r   <= input_halve_enable ? 2'h2 : 2'h1;
            core_den_r <= {1'b0, post_divide_factor} << 1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset output and external strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_output_n <= 1'b0;
        end else begin
            core_reset_output_n <= core_rst_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_oe <= 1'b0;
            rd_n_o    <= 1'b1;
            wr_n_o    <= 1'b1;
            ale_o     <= 1'b0;
        end else begin
            strobe_oe <= ext_rel;
            rd_n_o    <= ext_rel ? core_rd_n : 1'b1;
            wr_n_o    <= ext_rel ? core_wr_n : 1'b1;
            ale_o     <= ext_rel ? core_ale : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    post_force_a: assert property (@(posedge pclk) disable iff (!presetn)
        in_reset |=> post_divide_factor == 4'h1)
        else $error("post divide factor not 1 during reset");

    post_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        !in_reset |=> post_divide_factor == pcc_pkg::pcc_post_dec($past(ctrl_div_r)))
        else $error("post divide factor does not follow divider code");

    strap_mult_a: assert property (@(posedge pclk) disable iff (!presetn)
        in_reset |=> vco_multiplier == pcc_pkg::pcc_strap_mult($past(strap_s2_r)))
        else $error("multiplier not from strap during reset");

    strap_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        in_reset && strap_s2_r == 2'h1 && $stable(strap_s2_r) |=> ##1 ctrl_mult_r == 6'h20)
        else $error("strap code 01 did not give ratio 32");

    vco_ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(vco_multiplier) && $stable(post_divide_factor)
        |=> vco_num_r == 7'(2 * $past(vco_multiplier)) && core_den_r == 5'(2 * $past(post_divide_factor)))
        else $error("vco or core ratio does not match multiplier and factor");

    in_halve_a: assert property (@(posedge pclk) disable iff (!presetn)
        input_halve_enable |=> in_div_r == 2'h2)
        else $error("input halver enabled but input not halved");

    soft_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ok && pstrb[0] && !in_reset ##1 !in_reset
        |=> vco_multiplier == $past(pwdata[5:0], 2))
        else $error("software multiplier write did not take effect");

    strobe_z_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 strobe_oe == $past(ext_rel))
        else $error("strobe enable does not follow reset input");

    rst_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_rel |-> ##2 !core_reset_output_n)
        else $error("reset output released while reset input active");

    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb access not answered in one wait cycle");
endmodule : pcc_top

// File: tb/pcc_far_side.sv
// far-side model: free-running reference oscillator and external reset source
// assumes rst_req_n from the bench; reset pin moves on falling reference edges
module pcc_far_side #(
    parameter real REF_HALF_NS = 51.0
) (
    input  wire logic rst_req_n,
    output logic      reference_clock_in,
    output logic      ext_reset_n
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] low_cnt_r;

    initial begin
        reference_clock_in = 1'h0;
        ext_reset_n = 1'h0;
        low_cnt_r = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator, never halted
    always #(REF_HALF_NS) reference_clock_in = ~reference_clock_in;

    ////////////////////////////////////////////////////////////////////////
    // reset pin, held low for at least five reference cycles
    always @(negedge reference_clock_in) begin
        if (!rst_req_n && ext_reset_n) begin
            ext_reset_n <= 1'h0;
            low_cnt_r <= 3'h0;
        end else if (!ext_reset_n) begin
            if (low_cnt_r != 3'h4) begin
                low_cnt_r <= low_cnt_r + 3'h1;
            end else if (rst_req_n) begin
                ext_reset_n <= 1'h1;
            end
        end
    end
endmodule : pcc_far_side

// File: tb/pcc_top_tb.sv
// self-checking bench of the clock ratio and core reset control
// assumes pcc_consts.svh on the include path; apb master on pclk
`include "pcc_consts.svh"
module pcc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int  REF_CYC = 8;
    localparam real T_PCLK  = 25.0;
    localparam real T_REF   = 102.0;
    localparam real LO_NS   = REF_CYC * T_REF - T_REF / 2 + 4 * T_PCLK;
    localparam real HI_NS   = (REF_CYC + 1) * T_REF + 16 * T_PCLK;

    typedef struct packed {
        logic [1:0] code;
        logic [5:0] mult;
        logic       halve;
        logic [3:0] fac;
    } pcc_row_s;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, e;
    logic [3:0]  pstrb, post_divide_factor;
    logic        ext_reset_n, reference_clock_in, rst_req_n, err;
    logic [1:0]  startup_ratio;
    logic        core_rd_n, core_wr_n, core_ale, rd_n_o, wr_n_o, ale_o, strobe_oe;
    logic        core_reset_output_n, core_clock, periph_clock, input_halve_enable;
    logic [5:0]  vco_multiplier;
    int          n_errors, n_compared, cyc, n;
    // halver on for the larger multipliers keeps ref times multiplier in range
    pcc_row_s    rows [4] = '{'{2'h0, 6'h0a, 1'h0, 4'h1}, '{2'h1, 6'h14, 1'h1, 4'h2},
                              '{2'h2, 6'h20, 1'h1, 4'h4}, '{2'h3, 6'h05, 1'h0, 4'h8}};
    logic [1:0]  codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [5:0]  mults [4] = '{6'h20, 6'h10, 6'h06, 6'h06};

    pcc_top #(.REF_CYC(REF_CYC), .CORE_CYC(2)) u_pcc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_n(ext_reset_n), .reference_clock_in(reference_clock_in),
        .startup_ratio(startup_ratio), .core_rd_n(core_rd_n), .core_wr_n(core_wr_n),
        .core_ale(core_ale), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .ale_o(ale_o),
        .strobe_oe(strobe_oe), .core_reset_output_n(core_reset_output_n),
        .core_clock(core_clock), .periph_clock(periph_clock), .vco_multiplier(vco_multiplier),
        .post_divide_factor(post_divide_factor), .input_halve_enable(input_halve_enable));

    pcc_far_side #(.REF_HALF_NS(T_REF / 2)) u_pcc_far_side (
        .rst_req_n(rst_req_n), .reference_clock_in(reference_clock_in),
        .ext_reset_n(ext_reset_n));

    ////////////////////////////////////////////////////////////////////////
    // clock and cycle ceiling
    always #(T_PCLK / 2) pclk = ~pclk;

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wait_ext_low();
        while (ext_reset_n !== 1'h0) @(posedge pclk);
        repeat (6) @(posedge pclk);
        #1;
    endtask : wait_ext_low

    task automatic release_chk();
        realtime t0;
        @(posedge pclk);
        rst_req_n <= 1'h1;
        @(posedge ext_reset_n);
        t0 = $realtime;
        for (int i = 0; i < 400 && core_reset_output_n !== 1'h1; i++) @(posedge pclk);
        n_compared++;
        if ($realtime - t0 < LO_NS || $realtime - t0 > HI_NS) begin
            n_errors++;
            $display("[FAIL] release_ns expected %0.0f..%0.0f seen %0.0f", LO_NS, HI_NS, $realtime - t0);
        end
    endtask : release_chk

    task automatic clk_period(input logic sel);
        logic prev, cur;
        int   k;
        @(posedge pclk);
        #1;
        prev = sel ? periph_clock : core_clock;
        k = 0;
        n = 0;
        for (int i = 0; i < 100 && k < 2; i++) begin
            @(posedge pclk);
            #1;
            cur = sel ? periph_clock : core_clock;
            if (k == 1) n++;
            if (cur && !prev) k++;
            prev = cur;
        end
    endtask : clk_period

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {rst_req_n, core_ale, n_errors, n_compared, cyc} = '0;
        pstrb = 4'hf;
        startup_ratio = 2'h1;
        core_rd_n = 1'h1;
        core_wr_n = 1'h1;
        repeat (4) @(posedge pclk);
        #1;
        chk("rst_pins", 32'h0000_0018, {pready, pslverr, strobe_oe, rd_n_o, wr_n_o, ale_o,
            core_reset_output_n, core_clock});
        chk("rst_ratio", 32'h0000_0610, {vco_multiplier, post_divide_factor, input_halve_enable, 3'h0});
        presetn <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            startup_ratio <= codes[k];
            rst_req_n <= 1'h0;
            wait_ext_low();
            chk("strap_mult", 32'(mults[k]), 32'(vco_multiplier));
            chk("oe_in_reset", 32'h0, 32'(strobe_oe));
            chk("core_rst_pin", 32'h0, 32'(core_reset_output_n));
            apb(1'h1, `PCC_OFS_CTRL, 32'h0000_0009);
            #1;
            chk("mult_write_in_reset", 32'(mults[k]), 32'(vco_multiplier));
            release_chk();
        end
        @(posedge pclk);
        core_rd_n <= 1'h0;
        core_ale <= 1'h1;
        core_wr_n <= 1'h0;
        repeat (3) @(posedge pclk);
        #1;
        chk("strobes", 32'h0000_0003, {rd_n_o, wr_n_o, ale_o, strobe_oe});
        foreach (rows[k]) begin
            apb(1'h1, `PCC_OFS_CTRL, {23'h0, rows[k].halve, rows[k].code, rows[k].mult});
            repeat (20) @(posedge pclk);
            #1;
            chk("mult", 32'(rows[k].mult), 32'(vco_multiplier));
            chk("factor", 32'(rows[k].fac), 32'(post_divide_factor));
            chk("halve", 32'(rows[k].halve), 32'(input_halve_enable));
            e = {11'h0, 5'(2 * rows[k].fac), 6'h0, rows[k].halve ? 2'h2 : 2'h1, 1'h0, 7'(2 * rows[k].mult)};
            apb(1'h0, `PCC_OFS_RATIO, 32'h0);
            chk("ratio", e, rd);
            clk_period(1'h0);
            chk("core_period", 32'(2 * rows[k].fac), 32'(n));
            clk_period(1'h1);
            chk("periph_period", 32'(4 * rows[k].fac), 32'(n));
        end
        apb(1'h0, `PCC_OFS_CTRL, 32'h0);
        chk("ctrl_read", 32'h0000_00c5, rd);
        apb(1'h1, `PCC_OFS_STAT, 32'h0000_00ff);
        apb(1'h0, `PCC_OFS_STAT, 32'h0);
        chk("stat", 32'h0000_0083, rd);
        apb(1'h0, 12'h00c, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        @(posedge pclk);
        rst_req_n <= 1'h0;
        wait_ext_low();
        chk("factor_in_reset", 32'h1, 32'(post_divide_factor));
        chk("strobes_in_reset", 32'h0000_000c, {rd_n_o, wr_n_o, ale_o, strobe_oe});
        @(posedge pclk);
        rst_req_n <= 1'h1;
        @(posedge ext_reset_n);
        #(4 * T_REF);
        chk("core_mid_count", 32'h0, 32'(core_reset_output_n));
        @(posedge pclk);
        rst_req_n <= 1'h0;
        wait_ext_low();
        release_chk();
        wrap_up();
    end
endmodule : pcc_top_tb
